// *** src/ssr_pkg.sv ***
// package: constants, types and register map of the supply supervisor and regulator control
package ssr_pkg;

  // apb register map, byte addresses
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFS_CTRL   = 8'h00;
  localparam logic [7:0]  OFS_STATUS = 8'h04;
  localparam logic [7:0]  OFS_MASK   = 8'h08;
  localparam logic [7:0]  OFS_STATE  = 8'h0C;

  // control register fields
  localparam int unsigned LVL_W              = 3;
  localparam int unsigned CTRL_DET_EN_BIT    = 0;
  localparam int unsigned CTRL_DET_LVL_LSB   = 1;
  localparam int unsigned CTRL_HALT_VOFF_BIT = 4;
  localparam int unsigned CTRL_W             = 5;
  localparam logic [4:0]  CTRL_RESET         = 5'h00;

  // event status / mask fields
  localparam int unsigned EV_W        = 2;
  localparam int unsigned EV_FALL_BIT = 0;
  localparam int unsigned EV_RISE_BIT = 1;
  localparam logic [1:0]  EV_RESET    = 2'h0;

  // state register fields
  localparam int unsigned ST_BOR_LVL_LSB = 0;
  localparam int unsigned ST_BOR_ON_BIT  = 3;
  localparam int unsigned ST_DET_HI_BIT  = 4;
  localparam int unsigned ST_LP_REG_BIT  = 5;
  localparam int unsigned ST_RUN_BIT     = 6;

  // brownout option byte layout
  localparam int unsigned OPT_BOR_ON_BIT = 0;
  localparam int unsigned OPT_BOR_TH_LSB = 1;

  // threshold codes: five brownout levels, seven detector levels
  localparam logic [2:0] BOR_LVL_LOWEST = 3'h0;
  localparam logic [2:0] BOR_LVL_MAX    = 3'h4;
  localparam logic [2:0] DET_LVL_MAX    = 3'h6;

  // analog reference / comparator settling after enable or level change
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W      = 8;

  // core power modes
  typedef enum logic [2:0] {
    PM_RUN, PM_WFI, PM_WFE, PM_HALT, PM_ACTIVE_HALT, PM_LP_RUN, PM_LP_WAIT
  } ssr_pmode_t;

  // reset sequencer states
  typedef enum logic [1:0] {SQ_POR_WAIT, SQ_OPT_REQ, SQ_APPLY, SQ_RUN} ssr_seq_t;

  // apb request from the master
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } ssr_apb_req_t;

  // raw comparator outputs, asynchronous to core_clk
  typedef struct packed {
    logic det_above;
    logic bor_above;
    logic por_ok;
  } ssr_cmp_t;

endpackage : ssr_pkg

// *** src/ssr_supervisor.sv ***
// supply supervisor: reset sequencing, option load, threshold detector, regulator mode
`timescale 1ns/10ps
`default_nettype none
module ssr_supervisor #(
  parameter int unsigned SETTLE_CYCLES = ssr_pkg::SETTLE_CYC
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire ssr_pkg::ssr_apb_req_t apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire ssr_pkg::ssr_cmp_t     supply_in,
  input  wire ssr_pkg::ssr_pmode_t   pwr_mode,
  output logic                       opt_rd_req,
  input  wire logic                  opt_rd_valid,
  input  wire logic [7:0]            opt_rd_data,
  output logic                       brownout_reset_en,
  output logic [2:0]                 brownout_level,
  output logic                       vref_en,
  output logic                       supply_threshold_detector_en,
  output logic [2:0]                 detector_trip_level,
  output logic                       main_regulator_mode,
  output logic                       low_power_regulator_mode,
  output logic                       chip_rst_n,
  output logic                       irq
);

  // low power regulator modes, decoded in two places
  function automatic logic is_lp_mode(input ssr_pkg::ssr_pmode_t m);
    is_lp_mode = (m == ssr_pkg::PM_HALT) || (m == ssr_pkg::PM_ACTIVE_HALT) ||
                 (m == ssr_pkg::PM_LP_RUN) || (m == ssr_pkg::PM_LP_WAIT);
  endfunction : is_lp_mode

  // clamp a threshold code to the highest legal one
  function automatic logic [2:0] clamp_lvl(input logic [2:0] v, input logic [2:0] top);
    clamp_lvl = (v > top) ? top : v;
  endfunction : clamp_lvl

  logic [2:0]                  cmp_raw;
  logic [2:0]                  cmp_meta_r;
  logic [2:0]                  cmp_sync_r;
  logic                        por_ok;
  logic                        bor_ok;
  logic                        det_hi;
  ssr_pkg::ssr_seq_t           seq_r;
  ssr_pkg::ssr_seq_t           seq_nxt;
  logic                        bor_on_r;
  logic [2:0]                  bor_th_r;
  logic                        opt_loaded_r;
  logic [ssr_pkg::CTRL_W-1:0]  ctrl_r;
  logic [ssr_pkg::EV_W-1:0]    status_r;
  logic [ssr_pkg::EV_W-1:0]    status_nxt;
  logic [ssr_pkg::EV_W-1:0]    mask_r;
  logic [ssr_pkg::EV_W-1:0]    rd_cap_r;
  logic                        ctl_det_en;
  logic                        ctl_halt_voff;
  logic [2:0]                  ctl_det_lvl;
  logic                        in_halt;
  logic                        vref_nxt;
  logic                        bor_en_nxt;
  logic [1:0]                  settle_run;
  logic [1:0]                  settle_restart;
  logic [1:0]                  settled;
  logic                        det_active;
  logic                        det_armed_r;
  logic                        det_hi_d_r;
  logic                        det_fall;
  logic                        det_rise;
  logic                        bor_trip;
  logic                        apb_setup;
  logic                        apb_access;
  logic                        apb_wr;
  logic                        apb_rd_status;
  logic                        addr_hit;
  logic [31:0]                 rd_mux;
  logic [31:0]                 prdata_r;

  // analog comparator outputs: two flops each, only the second is read
  assign cmp_raw = {supply_in.det_above, supply_in.bor_above, supply_in.por_ok};
  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        cmp_meta_r[gi] <= 1'b0;
        cmp_sync_r[gi] <= 1'b0;
      end else begin
        cmp_meta_r[gi] <= cmp_raw[gi];
        cmp_sync_r[gi] <= cmp_meta_r[gi];
      end
    end
  end
  assign por_ok = cmp_sync_r[0];
  assign bor_ok = cmp_sync_r[1];
  assign det_hi = cmp_sync_r[2];

  // control fields
  assign ctl_det_en    = ctrl_r[ssr_pkg::CTRL_DET_EN_BIT];
  assign ctl_halt_voff = ctrl_r[ssr_pkg::CTRL_HALT_VOFF_BIT];
  assign ctl_det_lvl   = clamp_lvl(ctrl_r[ssr_pkg::CTRL_DET_LVL_LSB +: ssr_pkg::LVL_W],
                                   ssr_pkg::DET_LVL_MAX);

  // reference off only in halt, only while running, and only when asked
  assign in_halt    = (pwr_mode == ssr_pkg::PM_HALT);
  assign vref_nxt   = !((seq_nxt == ssr_pkg::SQ_RUN) && ctl_halt_voff && in_halt);
  // before options apply brownout is forced on; later the option bit rules while the reference stays on
  assign bor_en_nxt = (seq_nxt != ssr_pkg::SQ_RUN) ? 1'b1 : (bor_on_r && vref_nxt);

  // settle timers: [0] brownout comparator, [1] threshold detector
  // comparators are blind while the reference or a level is still moving
  assign settle_run[0]     = brownout_reset_en;
  assign settle_restart[0] = (seq_nxt != seq_r) || !brownout_reset_en;
  assign settle_run[1]     = det_active;
  assign settle_restart[1] = !det_active || (detector_trip_level != ctl_det_lvl);
  for (genvar gs = 0; gs < 2; gs++) begin : g_settle
    logic [ssr_pkg::SETTLE_W-1:0] cnt_r;
    always_ff @(posedge core_clk) begin
      if (!rst_n || settle_restart[gs]) begin
        cnt_r <= '0;
      end else if (settle_run[gs] && !settled[gs]) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
    assign settled[gs] = (cnt_r >= ssr_pkg::SETTLE_W'(SETTLE_CYCLES));
  end

  // brownout trips only once the comparator has settled on its level
  assign bor_trip = brownout_reset_en && settled[0] && !bor_ok;

  // reset sequencer: power-on wait, option read, apply level, run
  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      ssr_pkg::SQ_POR_WAIT: begin
        if (por_ok && bor_ok && settled[0]) begin
          seq_nxt = ssr_pkg::SQ_OPT_REQ;
        end
      end
      ssr_pkg::SQ_OPT_REQ: begin
        if (opt_rd_valid) begin
          seq_nxt = ssr_pkg::SQ_APPLY;
        end
      end
      ssr_pkg::SQ_APPLY: begin
        // wait for the chosen level to settle and, with brownout enabled, the supply to clear it
        if (settled[0] && (bor_ok || !bor_on_r)) begin
          seq_nxt = ssr_pkg::SQ_RUN;
        end
      end
      ssr_pkg::SQ_RUN: begin
        if (bor_trip) begin
          seq_nxt = ssr_pkg::SQ_POR_WAIT;
        end
      end
      default: seq_nxt = ssr_pkg::SQ_POR_WAIT;
    endcase
    if (!por_ok) begin
      seq_nxt = ssr_pkg::SQ_POR_WAIT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      seq_r <= ssr_pkg::SQ_POR_WAIT;
    end else begin
      seq_r <= seq_nxt;
    end
  end

  // option byte capture; a lost supply forces a fresh read next time
  always_ff @(posedge core_clk) begin
    if (!rst_n || (seq_nxt == ssr_pkg::SQ_POR_WAIT)) begin
      bor_on_r     <= 1'b1;
      bor_th_r     <= ssr_pkg::BOR_LVL_LOWEST;
      opt_loaded_r <= 1'b0;
    end else if ((seq_r == ssr_pkg::SQ_OPT_REQ) && opt_rd_valid) begin
      bor_on_r     <= opt_rd_data[ssr_pkg::OPT_BOR_ON_BIT];
      bor_th_r     <= clamp_lvl(opt_rd_data[ssr_pkg::OPT_BOR_TH_LSB +: ssr_pkg::LVL_W],
                                ssr_pkg::BOR_LVL_MAX);
      opt_loaded_r <= 1'b1;
    end
  end

  // registered analog and reset outputs, aligned with seq_r
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      brownout_reset_en            <= 1'b1;
      brownout_level               <= ssr_pkg::BOR_LVL_LOWEST;
      vref_en                      <= 1'b1;
      supply_threshold_detector_en <= 1'b0;
      detector_trip_level          <= 3'h0;
      chip_rst_n                   <= 1'b0;
      opt_rd_req                   <= 1'b0;
    end else begin
      brownout_reset_en            <= bor_en_nxt;
      brownout_level               <= (seq_nxt == ssr_pkg::SQ_POR_WAIT) ?
                                      ssr_pkg::BOR_LVL_LOWEST : bor_th_r;
      vref_en                      <= vref_nxt;
      supply_threshold_detector_en <= ctl_det_en && vref_nxt;
      detector_trip_level          <= ctl_det_lvl;
      chip_rst_n                   <= (seq_nxt == ssr_pkg::SQ_RUN);
      opt_rd_req                   <= (seq_nxt == ssr_pkg::SQ_OPT_REQ);
    end
  end

  // regulator follows the power mode by itself, halt entry included
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      main_regulator_mode      <= 1'b1;
      low_power_regulator_mode <= 1'b0;
    end else begin
      main_regulator_mode      <= !is_lp_mode(pwr_mode);
      low_power_regulator_mode <= is_lp_mode(pwr_mode);
    end
  end

  // detector crossings; the first settled sample only arms the edge logic
  assign det_active = supply_threshold_detector_en && ctl_det_en;
  assign det_fall   = det_armed_r && settled[1] && det_hi_d_r && !det_hi;
  assign det_rise   = det_armed_r && settled[1] && !det_hi_d_r && det_hi;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      det_armed_r <= 1'b0;
      det_hi_d_r  <= 1'b0;
    end else begin
      det_armed_r <= det_active && settled[1];
      det_hi_d_r  <= det_hi;
    end
  end

  // apb decode; the slave never waits
  assign pready        = 1'b1;
  assign apb_setup     = apb_req.psel && !apb_req.penable;
  assign apb_access    = apb_req.psel && apb_req.penable;
  assign addr_hit      = (apb_req.paddr == ssr_pkg::OFS_CTRL) ||
                         (apb_req.paddr == ssr_pkg::OFS_STATUS) ||
                         (apb_req.paddr == ssr_pkg::OFS_MASK) ||
                         (apb_req.paddr == ssr_pkg::OFS_STATE);
  assign pslverr       = apb_access && !addr_hit;
  assign apb_wr        = apb_access && apb_req.pwrite && addr_hit;
  assign apb_rd_status = apb_access && !apb_req.pwrite &&
                         (apb_req.paddr == ssr_pkg::OFS_STATUS);

  // read mux, sampled in the setup cycle so prdata comes from a flop
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (apb_req.paddr)
      ssr_pkg::OFS_CTRL:   rd_mux[ssr_pkg::CTRL_W-1:0] = ctrl_r;
      ssr_pkg::OFS_STATUS: rd_mux[ssr_pkg::EV_W-1:0]   = status_r;
      ssr_pkg::OFS_MASK:   rd_mux[ssr_pkg::EV_W-1:0]   = mask_r;
      ssr_pkg::OFS_STATE: begin
        rd_mux[ssr_pkg::ST_BOR_LVL_LSB +: ssr_pkg::LVL_W] = brownout_level;
        rd_mux[ssr_pkg::ST_BOR_ON_BIT]                    = brownout_reset_en;
        rd_mux[ssr_pkg::ST_DET_HI_BIT]                    = det_hi;
        rd_mux[ssr_pkg::ST_LP_REG_BIT]                    = low_power_regulator_mode;
        rd_mux[ssr_pkg::ST_RUN_BIT]                       = chip_rst_n;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // a read clears only the bits it returned, so a new event is never lost
  assign status_nxt = (status_r & ~(apb_rd_status ? rd_cap_r : ssr_pkg::EV_RESET)) |
                      {det_rise, det_fall};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
      rd_cap_r <= ssr_pkg::EV_RESET;
    end else if (apb_setup) begin
      prdata_r <= rd_mux;
      rd_cap_r <= status_r;
    end
  end
  assign prdata = prdata_r;

  // software registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r   <= ssr_pkg::CTRL_RESET;
      mask_r   <= ssr_pkg::EV_RESET;
      status_r <= ssr_pkg::EV_RESET;
    end else begin
      status_r <= status_nxt;
      if (apb_wr && (apb_req.paddr == ssr_pkg::OFS_CTRL)) begin
        ctrl_r <= apb_req.pwdata[ssr_pkg::CTRL_W-1:0];
      end
      if (apb_wr && (apb_req.paddr == ssr_pkg::OFS_MASK)) begin
        mask_r <= apb_req.pwdata[ssr_pkg::EV_W-1:0];
      end
    end
  end

  // level interrupt: each direction gated by its own mask bit
  assign irq = |(status_r & mask_r);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_boot_bor_on: assert property ((seq_r != ssr_pkg::SQ_RUN) |->
    brownout_reset_en && (chip_rst_n == 1'b0)) else $error("brownout off before run");
  chk_opt_after_bor: assert property ($rose(opt_rd_req) |->
    $past(por_ok) && $past(bor_ok) && (brownout_level == ssr_pkg::BOR_LVL_LOWEST))
    else $error("option read before brownout level");
  chk_bor_level_max: assert property (brownout_level <= ssr_pkg::BOR_LVL_MAX)
    else $error("brownout level out of range");
  chk_halt_vref_off: assert property ((seq_nxt == ssr_pkg::SQ_RUN && ctl_halt_voff &&
    in_halt) |=> !vref_en && !brownout_reset_en) else $error("reference on in halt");
  chk_low_supply_rst: assert property ((chip_rst_n && !por_ok) |=> !chip_rst_n)
    else $error("reset not taken on low supply");
  chk_det_level_max: assert property (detector_trip_level <= ssr_pkg::DET_LVL_MAX)
    else $error("detector level out of range");
  chk_fall_sets_flag: assert property ((det_fall && mask_r[ssr_pkg::EV_FALL_BIT])
    |=> status_r[ssr_pkg::EV_FALL_BIT] && irq) else $error("falling crossing lost");
  chk_det_off_quiet: assert property (!ctl_det_en |-> ##1 !det_fall && !det_rise)
    else $error("detector event while disabled");
  chk_main_reg_run: assert property ((pwr_mode inside {ssr_pkg::PM_RUN, ssr_pkg::PM_WFI,
    ssr_pkg::PM_WFE}) |=> main_regulator_mode && !low_power_regulator_mode)
    else $error("main regulator not selected");
  chk_lp_reg_halt: assert property (is_lp_mode(pwr_mode) |=>
    low_power_regulator_mode && !main_regulator_mode) else $error("low power regulator missed");
  chk_halt_entry_lp: assert property ((pwr_mode inside {ssr_pkg::PM_HALT,
    ssr_pkg::PM_ACTIVE_HALT}) |=> low_power_regulator_mode)
    else $error("halt entry kept main regulator");
  chk_sync_two_lag: assert property ($past(rst_n, 2) |->
    cmp_sync_r == $past(cmp_raw, 2)) else $error("comparator not two-stage synchronised");
  chk_rst_after_opt: assert property ($rose(chip_rst_n) |-> opt_loaded_r &&
    (brownout_level == bor_th_r)) else $error("reset released before options applied");

endmodule : ssr_supervisor
`default_nettype wire

// *** verif/ssr_supply_model.sv ***
// partner model: supply comparators and option byte store behind the supervisor
`timescale 1ns/10ps
`default_nettype none
module ssr_supply_model (
  input  wire logic              core_clk,
  input  wire logic              por_lvl,
  input  wire logic              bor_lvl,
  input  wire logic              det_lvl,
  input  wire logic [7:0]        opt_byte,
  input  wire logic [3:0]        opt_delay,
  input  wire logic              opt_rd_req,
  output logic                   opt_rd_valid,
  output logic [7:0]             opt_rd_data,
  output wire ssr_pkg::ssr_cmp_t supply_in
);
  logic [3:0] wait_r;

  // comparator levels follow the supply set by the bench, async to the core clock
  assign supply_in = {det_lvl, bor_lvl, por_lvl};

  initial begin
    opt_rd_valid = 1'b0;
    opt_rd_data  = 8'h00;
    wait_r       = 4'h0;
  end

  // answer each option read after a variable delay, so no fixed latency is assumed
  always @(posedge core_clk) begin
    if (!opt_rd_req || opt_rd_valid) begin
      wait_r       <= opt_delay;
      opt_rd_valid <= 1'b0;
      opt_rd_data  <= ~opt_byte;  // idle bus shows no stale byte
    end else if (wait_r == 4'h0) begin
      opt_rd_valid <= 1'b1;
      opt_rd_data  <= opt_byte;
    end else begin
      wait_r <= wait_r - 4'h1;
    end
  end
endmodule : ssr_supply_model
`default_nettype wire

// *** verif/supply_supervisor_regulator_ctrl_test.sv ***
// testbench: reset sequencing, option load, detector events and regulator mode
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor_regulator_ctrl_test;
  localparam int unsigned SETTLE = 4;  // short settle keeps the run brief
  logic                  core_clk, rst_n, pready, pslverr, opt_rd_req, opt_rd_valid;
  logic                  bre, vref_en, det_en, main_rm, lp_rm, chip_rst_n, irq, err;
  logic                  por_lvl, bor_lvl, det_lvl;
  logic [31:0]           prdata, rd;
  logic [7:0]            opt_rd_data, opt_byte;
  logic [3:0]            opt_delay;
  logic [2:0]            bor_level, det_level;
  ssr_pkg::ssr_apb_req_t apb_req;
  ssr_pkg::ssr_pmode_t   pwr_mode;
  ssr_pkg::ssr_cmp_t     supply_in;
  integer                seed, mismatches, comparisons;

  ssr_supervisor #(.SETTLE_CYCLES(SETTLE)) dut (.core_clk(core_clk), .rst_n(rst_n),
    .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .supply_in(supply_in), .pwr_mode(pwr_mode), .opt_rd_req(opt_rd_req),
    .opt_rd_valid(opt_rd_valid), .opt_rd_data(opt_rd_data), .brownout_reset_en(bre),
    .brownout_level(bor_level), .vref_en(vref_en), .supply_threshold_detector_en(det_en),
    .detector_trip_level(det_level), .main_regulator_mode(main_rm),
    .low_power_regulator_mode(lp_rm), .chip_rst_n(chip_rst_n), .irq(irq));
  ssr_supply_model model (.core_clk(core_clk), .por_lvl(por_lvl), .bor_lvl(bor_lvl),
    .det_lvl(det_lvl), .opt_byte(opt_byte), .opt_delay(opt_delay), .opt_rd_req(opt_rd_req),
    .opt_rd_valid(opt_rd_valid), .opt_rd_data(opt_rd_data), .supply_in(supply_in));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; the request holds until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    apb_req <= '0;
  endtask : apb

  // drop the supply below the power-down level, then bring it up with option byte ob
  task automatic power_up(input logic [7:0] ob);
    logic [2:0] lvl;
    lvl = (ob[3:1] > ssr_pkg::BOR_LVL_MAX) ? ssr_pkg::BOR_LVL_MAX : ob[3:1];
    @(posedge core_clk);
    por_lvl   <= 1'b0;
    opt_byte  <= ob;
    opt_delay <= 4'($random(seed));
    repeat (5) @(posedge core_clk);
    chk("chip_rst_n low", 32'h0, chip_rst_n);
    chk("brownout forced", 32'h1, bre);
    por_lvl <= 1'b1;
    for (int i = 0; i < 100 && opt_rd_req !== 1'b1; i++) @(posedge core_clk);
    chk("opt_rd_req", 32'h1, opt_rd_req);
    chk("held in load", 32'h0, chip_rst_n);
    for (int i = 0; i < 200 && chip_rst_n !== 1'b1; i++) @(posedge core_clk);
    chk("chip_rst_n up", 32'h1, chip_rst_n);
    chk("brownout on", 32'(ob[0]), bre);
    if (ob[0]) chk("brownout_level", 32'(lvl), bor_level);
  endtask : power_up

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    logic [2:0] lvl;
    seed = 32'hD8C6E907;
    mismatches = 0;
    comparisons = 0;
    rst_n = 1'b0;
    apb_req = '0;
    pwr_mode = ssr_pkg::PM_RUN;
    {por_lvl, bor_lvl, det_lvl} = 3'h1;
    opt_byte = 8'h00;
    opt_delay = 4'h0;
    repeat (4) @(posedge core_clk);
    chk("rst chip", 32'h0, chip_rst_n);
    chk("rst brownout", 32'h1, bre);
    chk("rst level", 32'h0, bor_level);
    chk("rst detector", 32'h0, det_en);
    chk("rst main reg", 32'h1, main_rm);
    rst_n   <= 1'b1;
    bor_lvl <= 1'b1;
    for (int c = 0; c < 8; c++) power_up({4'h0, 3'(c), 1'b1});
    $display("test option levels done");
    power_up(8'($random(seed)) & 8'hFE);
    bor_lvl <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("brownout off", 32'h1, chip_rst_n);
    bor_lvl <= 1'b1;
    power_up(8'h05);
    bor_lvl <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk("brownout trip", 32'h0, chip_rst_n);
    bor_lvl <= 1'b1;
    power_up(8'h05);
    $display("test brownout done");
    apb(1'b0, ssr_pkg::OFS_STATE, 32'h0);
    chk("state", 32'h5A, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk("unmapped wr err", 32'h1, err);
    chk("pready", 32'h1, pready);
    // detector: random trip level, fall and rise events, mask gating the interrupt
    lvl = 3'($unsigned($random(seed)) % 7);
    apb(1'b1, ssr_pkg::OFS_CTRL, {28'h0, lvl, 1'b1});
    repeat (2) @(posedge core_clk);
    chk("trip level", 32'(lvl), det_level);
    chk("detector on", 32'h1, det_en);
    apb(1'b0, ssr_pkg::OFS_CTRL, 32'h0);
    chk("ctrl readback", {28'h0, lvl, 1'b1}, rd);
    apb(1'b1, ssr_pkg::OFS_MASK, 32'h3);
    repeat (20) @(posedge core_clk);
    det_lvl <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk("irq fall", 32'h1, irq);
    apb(1'b0, ssr_pkg::OFS_STATUS, 32'h0);
    chk("status fall", 32'h1, rd);
    @(posedge core_clk);
    chk("irq cleared", 32'h0, irq);
    apb(1'b1, ssr_pkg::OFS_MASK, 32'h1);
    apb(1'b0, ssr_pkg::OFS_MASK, 32'h0);
    chk("mask readback", 32'h1, rd);
    det_lvl <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("irq masked", 32'h0, irq);
    apb(1'b0, ssr_pkg::OFS_STATUS, 32'h0);
    chk("status rise", 32'h2, rd);
    $display("test detector done");
    for (int m = 0; m < 7; m++) begin
      pwr_mode <= ssr_pkg::ssr_pmode_t'(m);
      repeat (2) @(posedge core_clk);
      chk("main mode", 32'(m < 3), main_rm);
      chk("lp mode", 32'(m >= 3), lp_rm);
    end
    pwr_mode <= ssr_pkg::PM_RUN;
    $display("test regulator done");
    apb(1'b1, ssr_pkg::OFS_CTRL, 32'h10);
    pwr_mode <= ssr_pkg::PM_HALT;
    repeat (3) @(posedge core_clk);
    chk("halt lp", 32'h1, lp_rm);
    chk("halt vref", 32'h0, vref_en);
    chk("halt brownout", 32'h0, bre);
    $display("test halt done");
    tally_and_finish();
  end
endmodule : supply_supervisor_regulator_ctrl_test
`default_nettype wire
